// ### src/ccs_channel_select.sv
`default_nettype none
`include "ccs_defs.svh"

module ccs_channel_select import ccs_pkg::*; #(
  parameter int DW = 16
) (
  input  wire logic          clk,          // system clock, 20 MHz
  input  wire logic          rst_n,        // async reset, active low
  input  wire logic          reg_wr,       // register byte write strobe
  input  wire logic          reg_rd,       // register byte read strobe
  input  wire logic [7:0]    reg_addr,     // register byte address
  input  wire logic [7:0]    reg_wdata,    // register write byte
  output logic               reg_hit,      // address belongs to this register
  output logic [7:0]         reg_rdata,    // read byte, registered
  output logic               reg_rvalid,   // read byte valid, one cycle
  input  wire logic          stack_sum_monitor_enable,   // self-test enable
  input  wire logic          charge_pump_monitor_enable, // self-test enable
  input  wire logic          cmd_start,    // execute conversion command
  output logic               cmd_busy,     // command in progress
  output logic               cmd_done,     // command finished, one cycle
  output logic               conv_valid,   // conversion request
  input  wire logic          conv_ready,   // engine accepts request
  output ccs_conv_t          conv_req,     // source of the request
  input  wire logic          conv_done,    // conversion finished pulse
  input  wire logic [DW-1:0] conv_data,    // conversion result
  output logic               res_valid,    // result byte available
  input  wire logic          res_ready,    // sink takes result byte
  output logic [7:0]         res_byte      // result byte, msb first
);

  // byte slicing of results assumes a 16-bit conversion word
  if (DW != 16) begin : g_dw_check
    $error("ccs_channel_select: result width must be 16 bits");
  end

  ccs_sel_t       chsel;
  logic [31:0]    next_chsel;
  logic [31:0]    pending;
  logic           stack_en_snap;
  logic           cpump_en_snap;
  logic           phase;
  logic [DW-1:0]  result;
  ccs_state_t     state;
  ccs_state_t     next_state;
  logic           found;
  logic [4:0]     cur_idx;
  logic [DW-1:0]  avg_val;
  logic [1:0]     lane;
  logic [3:0]     lane_wr;
  logic [7:0]     rd_byte;
  logic           take_cmd;
  logic           is_stack;
  logic           is_ref;
  logic           first_stack;
  logic           second_ref;
  logic           byte_hi_go;
  logic           byte_lo_go;
  ccs_conv_t      cur_conv;

  // address decode: only the four bytes of this register answer
  assign reg_hit = (reg_addr >= `CCS_ADDR_BASE) && (reg_addr <= `CCS_ADDR_LAST);
  assign lane    = 2'(reg_addr - `CCS_ADDR_BASE);

  // lowest address is the most significant byte
  genvar k;
  generate
    for (k = 0; k < `CCS_LANES; k++) begin : g_lane
      assign lane_wr[k] = reg_wr && reg_hit && (lane == 2'(k));
      assign next_chsel[31-8*k -: 8] = lane_wr[k] ? reg_wdata : chsel[31-8*k -: 8];
    end
  endgenerate

  assign rd_byte = 8'(32'(chsel) >> (8 * (3 - lane)));

  // reserved bits are dropped on write, so a careless host cannot select them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chsel <= `CCS_SEL_RESET;
    end else begin
      chsel <= next_chsel & ~`CCS_RSV_MASK;
    end
  end

  // read answer one cycle after the strobe; foreign addresses stay silent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= (reg_rd && reg_hit) ? rd_byte : 8'h00;
      reg_rvalid <= reg_rd && reg_hit;
    end
  end

  // highest pending bit is next, which yields cell 16 first
  ccs_scan #(.W(32), .IW(5)) u_scan (
    .mask  (pending),
    .found (found),
    .idx   (cur_idx)
  );

  ccs_avg #(.DW(DW)) u_avg (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (first_stack),
    .data  (conv_data),
    .avg   (avg_val)
  );

  // source decode of the bit being served
  assign is_stack = (cur_idx == 5'(`CCS_STACK_BIT));
  assign is_ref   = (cur_idx == 5'(`CCS_REF_BIT));

  always_comb begin
    cur_conv.chan = 4'h0;
    cur_conv.src  = CCS_SRC_GND;
    if (cur_idx >= 5'(`CCS_CELL_LSB)) begin
      cur_conv.src  = CCS_SRC_CELL;
      cur_conv.chan = cur_idx[3:0];
    end else if (cur_idx >= 5'(`CCS_AUX_LSB)) begin
      cur_conv.src  = CCS_SRC_AUX;
      cur_conv.chan = {1'b0, cur_idx[2:0]};
    end else begin
      case (cur_idx)
        5'(`CCS_DTEMP_BIT): cur_conv.src = CCS_SRC_DTEMP;
        5'(`CCS_ATEMP_BIT): cur_conv.src = CCS_SRC_ATEMP;
        5'(`CCS_CORE_BIT):  cur_conv.src = CCS_SRC_CORE;
        5'(`CCS_REF_BIT):   cur_conv.src = phase ? CCS_SRC_GND : CCS_SRC_REF45;
        5'(`CCS_STACK_BIT): cur_conv.src = stack_en_snap ? CCS_SRC_STACK : CCS_SRC_GND;
        5'(`CCS_CPUMP_BIT): cur_conv.src = cpump_en_snap ? CCS_SRC_CPUMP : CCS_SRC_GND;
        default:            cur_conv.src = CCS_SRC_GND;
      endcase
    end
  end

  // handshake terms of the sequencer
  assign take_cmd    = cmd_start && (state == CCS_IDLE);
  assign first_stack = (state == CCS_WAIT) && conv_done && is_stack && !phase;
  assign second_ref  = is_ref && !phase;
  assign byte_hi_go  = (state == CCS_HI) && res_ready;
  assign byte_lo_go  = (state == CCS_LO) && res_ready;

  assign conv_valid = (state == CCS_REQ);
  assign conv_req   = cur_conv;
  assign res_valid  = (state == CCS_HI) || (state == CCS_LO);
  assign cmd_busy   = (state != CCS_IDLE);
  assign cmd_done   = (state == CCS_SCAN) && !found;

  // next state of the command sequencer
  always_comb begin
    next_state = state;
    case (state)
      CCS_IDLE: if (take_cmd) next_state = CCS_SCAN;
      CCS_SCAN: next_state = found ? CCS_REQ : CCS_IDLE;
      CCS_REQ:  if (conv_ready) next_state = CCS_WAIT;
      CCS_WAIT: if (conv_done) next_state = first_stack ? CCS_REQ : CCS_HI;
      CCS_HI:   if (res_ready) next_state = CCS_LO;
      CCS_LO:   if (res_ready) next_state = second_ref ? CCS_REQ : CCS_SCAN;
      default:  next_state = CCS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // snapshot at command start: writes earlier in the frame are already in chsel,
  // later writes cannot disturb a command that is running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending       <= 32'h0000_0000;
      stack_en_snap <= 1'b0;
      cpump_en_snap <= 1'b0;
    end else if (take_cmd) begin
      pending       <= chsel & ~`CCS_RSV_MASK;
      stack_en_snap <= stack_sum_monitor_enable;
      cpump_en_snap <= charge_pump_monitor_enable;
    end else if (byte_lo_go && !second_ref) begin
      pending[cur_idx] <= 1'b0;
    end
  end

  // phase: second half of the reference pair or of the stack-sum pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
    end else if (take_cmd) begin
      phase <= 1'b0;
    end else if (first_stack || (byte_lo_go && second_ref)) begin
      phase <= 1'b1;
    end else if (byte_lo_go) begin
      phase <= 1'b0;
    end
  end

  // result and outgoing byte held in flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result   <= '0;
      res_byte <= 8'h00;
    end else if ((state == CCS_WAIT) && conv_done && !first_stack) begin
      result   <= (is_stack && phase) ? avg_val : conv_data;
      res_byte <= (is_stack && phase) ? avg_val[15:8] : conv_data[15:8];
    end else if (byte_hi_go) begin
      res_byte <= result[7:0];
    end
  end

  // checks rest while reset is low, so a reset mid-command cannot trip them
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // storage and byte lanes
  byte_order_a: assert property (lane_wr[0] |=> chsel[31:24] == $past(reg_wdata))
    else $error("lowest address did not land in bits 31:24");
  rsvd_zero_a: assert property (chsel.reserved == 2'b00)
    else $error("reserved bits stored nonzero");
  // source mapping of each request
  cell_map_a: assert property (conv_valid && conv_req.src == CCS_SRC_CELL
                               |-> pending[16 + conv_req.chan])
    else $error("cell requested that is not selected");
  aux_map_a: assert property (conv_valid && conv_req.src == CCS_SRC_AUX
                              |-> pending[8 + conv_req.chan] && conv_req.chan < 4'h8)
    else $error("aux requested that is not selected");
  temp_map_a: assert property (conv_valid && (conv_req.src == CCS_SRC_DTEMP
                               || conv_req.src == CCS_SRC_ATEMP || conv_req.src == CCS_SRC_CORE)
                               |-> pending[7 - (conv_req.src - CCS_SRC_DTEMP)])
    else $error("self-test source requested without its select bit");
  cell_src_a: assert property (conv_valid && cur_idx >= 5'h10
                               |-> conv_req.src == CCS_SRC_CELL && conv_req.chan == cur_idx[3:0])
    else $error("cell bit did not request its own cell");

  // pairs, the stack-sum average, monitor gating, byte order and the command snapshot
  ref_pair_a: assert property (byte_lo_go && second_ref |=> conv_valid
                               && conv_req.src == CCS_SRC_GND)
    else $error("ground did not follow the 4.5 V reference");
  stack_avg_a: assert property ((state == CCS_WAIT) && conv_done && is_stack && phase
                                |=> result == ($past(avg_val)))
    else $error("stack-sum result is not the average");
  stack_gnd_a: assert property (conv_valid && is_stack && !stack_en_snap
                                |-> conv_req.src == CCS_SRC_GND)
    else $error("stack sum converted while its monitor is off");
  cpump_src_a: assert property (conv_valid && cur_idx == 5'h0 && cpump_en_snap
                                |-> conv_req.src == CCS_SRC_CPUMP)
    else $error("charge-pump monitor not converted");
  msb_first_a: assert property (byte_hi_go |=> res_valid && res_byte == $past(result[7:0]))
    else $error("low byte did not follow high byte");
  snap_cmd_a: assert property (take_cmd |=> pending == ($past(chsel) & ~`CCS_RSV_MASK))
    else $error("command did not use current selection");
  snap_en_a: assert property (take_cmd |=>
                              stack_en_snap == $past(stack_sum_monitor_enable)
                              && cpump_en_snap == $past(charge_pump_monitor_enable))
    else $error("monitor enables not captured at command start");
  cpump_gnd_a: assert property (conv_valid && cur_idx == 5'h0 && !cpump_en_snap
                                |-> conv_req.src == CCS_SRC_GND)
    else $error("charge-pump rail converted while its monitor is off");

  // sequencing and handshakes: outputs hold until they are taken
  conv_hold_a: assert property (conv_valid && !conv_ready
                                |=> conv_valid && $stable(conv_req))
    else $error("conversion request changed before it was taken");
  res_hold_a: assert property (res_valid && !res_ready
                               |=> res_valid && $stable(res_byte))
    else $error("result byte changed before it was taken");
  scan_order_a: assert property (state == CCS_SCAN && found
                                 |-> (pending >> cur_idx) == 32'h0000_0001)
    else $error("scan did not pick the highest pending bit");
  done_idle_a: assert property (cmd_done |=> !cmd_busy)
    else $error("sequencer still busy after command done");
  rd_answer_a: assert property (reg_rd && reg_hit
                                |=> reg_rvalid && reg_rdata == $past(rd_byte))
    else $error("register read gave no answer");
  rd_silent_a: assert property (!(reg_rd && reg_hit) |=> !reg_rvalid)
    else $error("answer without a read of this register");

  // scenarios worth seeing
  stack_pair_c: cover property (first_stack ##[1:40] (state == CCS_HI) && is_stack);
  ref_pair_c:   cover property (byte_lo_go && second_ref);
  full_cmd_c:   cover property (take_cmd ##[1:200] cmd_done);
  cell16_first_c: cover property (take_cmd ##2 conv_valid && conv_req.src == CCS_SRC_CELL
                                  && conv_req.chan == 4'hF);
  cpump_gnd_c:    cover property (conv_valid && cur_idx == 5'h0 && !cpump_en_snap);

endmodule

`default_nettype wire

// ### inc/ccs_defs.svh
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// byte addresses of the channel selection register on the serial link
`define CCS_ADDR_BASE  8'h03
`define CCS_ADDR_LAST  8'h06
`define CCS_LANES      4

// reset contents: nothing selected
`define CCS_SEL_RESET  32'h0000_0000

// field positions inside the 32-bit channel selection word
`define CCS_CELL_MSB   31
`define CCS_CELL_LSB   16
`define CCS_AUX_MSB    15
`define CCS_AUX_LSB    8
`define CCS_DTEMP_BIT  7
`define CCS_ATEMP_BIT  6
`define CCS_CORE_BIT   5
`define CCS_RSV_HI_BIT 4
`define CCS_RSV_LO_BIT 3
`define CCS_REF_BIT    2
`define CCS_STACK_BIT  1
`define CCS_CPUMP_BIT  0

// reserved bits are kept at zero in storage
`define CCS_RSV_MASK   32'h0000_0018

`endif

// ### inc/ccs_pkg.sv
`default_nettype none

package ccs_pkg;

  // measurement source handed to the conversion engine
  typedef enum logic [3:0] {
    CCS_SRC_CELL,
    CCS_SRC_AUX,
    CCS_SRC_DTEMP,
    CCS_SRC_ATEMP,
    CCS_SRC_CORE,
    CCS_SRC_REF45,
    CCS_SRC_GND,
    CCS_SRC_STACK,
    CCS_SRC_CPUMP
  } ccs_src_t;

  // one conversion request: source and channel number within it
  typedef struct packed {
    ccs_src_t   src;
    logic [3:0] chan;
  } ccs_conv_t;

  // layout of the channel selection word, msb first
  typedef struct packed {
    logic [15:0] cell_voltage_select_mask;
    logic [7:0]  aux_input_select_mask;
    logic        digital_die_temp_select;
    logic        analog_die_temp_select;
    logic        core_supply_select;
    logic [1:0]  reserved;
    logic        reference_pair_select;
    logic        stack_sum_select;
    logic        charge_pump_monitor_select;
  } ccs_sel_t;

  // command sequencer states
  typedef enum logic [2:0] {
    CCS_IDLE,
    CCS_SCAN,
    CCS_REQ,
    CCS_WAIT,
    CCS_HI,
    CCS_LO
  } ccs_state_t;

endpackage

`default_nettype wire

// ### src/ccs_scan.sv
`default_nettype none

module ccs_scan import ccs_pkg::*; #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  mask,   // pending selection bits
  output logic               found,  // any bit set
  output logic [IW-1:0]      idx     // index of highest set bit
);

  // refuse an index too narrow to name every mask bit
  if (W < 2 || (1 << IW) < W) begin : g_width_check
    $error("ccs_scan: index width too small for mask width");
  end

  assign found = |mask;

  // ascending walk so the highest set bit wins, giving msb-first order
  always_comb begin
    idx = '0;
    for (int i = 0; i < W; i++) begin
      if (mask[i]) begin
        idx = IW'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ### src/ccs_avg.sv
`default_nettype none

module ccs_avg import ccs_pkg::*; #(
  parameter int DW = 16
) (
  input  wire logic          clk,    // system clock
  input  wire logic          rst_n,  // async reset, active low
  input  wire logic          load,   // capture first sample
  input  wire logic [DW-1:0] data,   // current conversion result
  output logic [DW-1:0]      avg     // mean of held sample and data
);

  logic [DW-1:0] first;
  logic [DW:0]   sum;

  // refuse widths that leave nothing to average
  if (DW < 2) begin : g_dw_check
    $error("ccs_avg: data width too small");
  end

  // hold the first of the two stack-sum conversions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first <= '0;
    end else if (load) begin
      first <= data;
    end
  end

  // one extra bit keeps the carry so the halving never wraps
  assign sum = {1'b0, first} + {1'b0, data};
  assign avg = sum[DW:1];

endmodule

`default_nettype wire

// ### bench/ccs_engine_model.sv
`default_nettype none

module ccs_engine_model import ccs_pkg::*; (
  input  wire logic        clk,        // system clock
  input  wire logic        rst_n,      // async reset, active low
  input  wire logic        slow,       // stretch conversion time
  input  wire logic        conv_valid, // request pending
  input  wire ccs_conv_t   conv_req,   // requested source
  output logic             conv_ready, // request accepted
  output logic             conv_done,  // conversion finished pulse
  output logic [15:0]      conv_data   // result, hi byte echoes request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pend;
  logic [2:0] wt;
  logic       tog;
  logic [7:0] held;

  // accepts one request at a time; data toggles when idle so a stale value never matches
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ready <= 1'b0;
      conv_done  <= 1'b0;
      conv_data  <= 16'h0000;
      pend       <= 1'b0;
      wt         <= 3'h0;
      tog        <= 1'b0;
      held       <= 8'h00;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_ready && !conv_valid) begin
        conv_ready <= 1'b0;
        pend       <= 1'b1;
        wt         <= slow ? 3'h4 : 3'h0;
      end else if (pend) begin
        if (wt == 3'h0) begin
          conv_done <= 1'b1;
          conv_data <= {held, 7'h24, tog}; // lsb alternates so averaging shows
          tog       <= ~tog;
          pend      <= 1'b0;
        end else begin
          wt <= wt - 3'h1;
        end
      end else if (conv_valid && !conv_ready) begin
        conv_ready <= 1'b1;
        held       <= conv_req;
      end
    end
  end
endmodule

`default_nettype wire

// ### bench/tb.sv
`default_nettype none

module tb import ccs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, reg_wr, reg_rd, reg_hit, reg_rvalid, sme, cpe, slow;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, res_byte;
  logic        cmd_start, cmd_busy, cmd_done, conv_valid, conv_ready, conv_done;
  logic        res_valid, res_ready;
  ccs_conv_t   conv_req;
  logic [15:0] conv_data;
  logic [7:0]  got[$];
  logic [7:0]  eq[$];
  logic        p;
  int          err_total, check_count, ndone, cyc;
  logic [31:0] tsel[11] = '{32'h8000_0000, 32'h0001_0000, 32'h0000_8100, 32'h0000_00E0,
                            32'h0000_0004, 32'h0000_0002, 32'h0000_0002, 32'h0000_0001,
                            32'h0000_0001, 32'hFFFF_FFE7, 32'h0000_0000};
  logic [2:0]  tflg[11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h2, 3'h0, 3'h7, 3'h0};

  ccs_channel_select dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_hit(reg_hit), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .stack_sum_monitor_enable(sme),
    .charge_pump_monitor_enable(cpe), .cmd_start(cmd_start), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
    .res_valid(res_valid), .res_ready(res_ready), .res_byte(res_byte));
  ccs_engine_model eng_u (.clk(clk), .rst_n(rst_n), .slow(slow), .conv_valid(conv_valid),
    .conv_req(conv_req), .conv_ready(conv_ready), .conv_done(conv_done),
    .conv_data(conv_data));

  // 20 MHz clock
  always #25 clk = ~clk;

  // result sink stalls every other cycle in slow runs
  always @(negedge clk) res_ready <= slow ? ~res_ready : 1'b1;

  // collect accepted result bytes, count done pulses, cut a hang short
  always @(posedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) got.push_back(res_byte);
    if (cmd_done === 1'b1) ndone++;
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      $display("[FAIL] timeout expected 30000 seen %0d", cyc);
      results();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    #1 chk("reg_hit", {7'h00, h}, {7'h00, reg_hit});
    @(negedge clk);
    reg_rd = 1'b0;
    chk("reg_rvalid", {7'h00, h}, {7'h00, reg_rvalid});
    chk("reg_rdata", e, reg_rdata);
  endtask

  // expected bytes of one selected item; averaged pair leaves lsb parity unchanged
  task automatic add(input logic [7:0] h, input bit pair);
    eq.push_back(h);
    eq.push_back(pair ? 8'h48 : {7'h24, p});
    if (!pair) p = ~p;
  endtask

  task automatic cmd(input logic [31:0] s, input logic [2:0] f);
    eq.delete();
    for (int b = 31; b >= 0; b--) begin
      if (s[b]) begin
        if (b >= 16) add({CCS_SRC_CELL, 4'(b - 16)}, 0);
        else if (b >= 8) add({CCS_SRC_AUX, 4'(b - 8)}, 0);
        else if (b == 7) add({CCS_SRC_DTEMP, 4'h0}, 0);
        else if (b == 6) add({CCS_SRC_ATEMP, 4'h0}, 0);
        else if (b == 5) add({CCS_SRC_CORE, 4'h0}, 0);
        else if (b == 2) begin
          add({CCS_SRC_REF45, 4'h0}, 0);
          add({CCS_SRC_GND, 4'h0}, 0);
        end
        else if (b == 1) add({f[2] ? CCS_SRC_STACK : CCS_SRC_GND, 4'h0}, 1);
        else if (b == 0) add({f[1] ? CCS_SRC_CPUMP : CCS_SRC_GND, 4'h0}, 0);
      end
    end
    for (int i = 0; i < 4; i++) wr(8'h03 + 8'(i), s[31 - 8 * i -: 8]);
    @(negedge clk);
    {sme, cpe, slow} = f;
    got.delete();
    ndone     = 0;
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    for (int k = 0; k < 3000 && (cmd_busy !== 1'b0 || ndone == 0); k++) @(negedge clk);
    chk("done_count", 8'h01, 8'(ndone));
    chk("byte_count", 8'(eq.size()), 8'(got.size()));
    for (int i = 0; i < eq.size() && i < got.size(); i++) chk("res_byte", eq[i], got[i]);
    $display("test command %h done", s);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // reset, register access, then the command table
  initial begin
    {clk, rst_n, reg_wr, reg_rd, sme, cpe, slow, cmd_start} = 8'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    err_total   = 0;
    check_count = 0;
    p = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rd(8'h03 + 8'(i), 8'h00, 1'b1);
    wr(8'h03, 8'h80);
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h5A);
    wr(8'h06, 8'hE7);
    wr(8'h07, 8'hAA);
    rd(8'h03, 8'h80, 1'b1);
    rd(8'h04, 8'h01, 1'b1);
    rd(8'h05, 8'h5A, 1'b1);
    rd(8'h06, 8'hE7, 1'b1);
    rd(8'h07, 8'h00, 1'b0);
    $display("test register access done");
    for (int t = 0; t < 11; t++) cmd(tsel[t], tflg[t]);
    results();
  end
endmodule

`default_nettype wire
